// file: design/iqs_bit_clock.sv
// Purpose: Serial bit clock divider
// Assumes: clk_i runs at twice the modulator clock rate
// Notes: Each half period lasts divisor_i clock cycles
`timescale 1ns/1ns
`default_nettype none
module iqs_bit_clock
    import iqs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] divisor_i,
    output logic level_o,
    output logic tick_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] cnt;
        logic level;
    } iqs_div_t;
    iqs_div_t cur;
    iqs_div_t next_cur;
    logic [3:0] last;

    // Zero is taken as one so the clock never stops
    assign last = (divisor_i == 4'h0) ? 4'h0 : divisor_i - 4'h1;
    assign tick_o = (cur.cnt >= last) && !cur.level;
    assign level_o = cur.level;

    always_comb
    begin
        next_cur = cur;
        if (cur.cnt >= last)
        begin
            next_cur.cnt = 4'h0;
            next_cur.level = !cur.level;
        end
        else
        begin
            next_cur.cnt = cur.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cur <= '0;
        else
            cur <= next_cur;
    end
endmodule : iqs_bit_clock
`default_nettype wire

// file: design/iqs_event_counter.sv
// Purpose: Two-bit saturating event counter
// Assumes: evt_i is a one-cycle pulse per event
// Notes: An event in the clearing cycle counts as one
`timescale 1ns/1ns
`default_nettype none
module iqs_event_counter
    import iqs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic evt_i,
    input wire logic clear_i,
    output logic [1:0] count_o
);
    typedef struct packed {
        logic [1:0] cnt;
    } iqs_cnt_t;
    iqs_cnt_t cur;
    iqs_cnt_t next_cur;

    assign count_o = cur.cnt;

    always_comb
    begin
        next_cur = cur;
        if (clear_i)
            next_cur.cnt = {1'b0, evt_i};
        else if (evt_i && (cur.cnt != IQS_CNT_MAX))
            next_cur.cnt = cur.cnt + 2'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cur <= '0;
        else
            cur <= next_cur;
    end
endmodule : iqs_event_counter
`default_nettype wire

// file: design/iqs_serial_port.sv
// Purpose: I/Q sample serial output port with Wishbone registers
// Assumes: One sample strobe per decimated output sample
// Notes: Divisor legality versus frame length is left to software
//
// Our own choice: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module iqs_serial_port
    import iqs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sample_valid_i,
    input wire logic [15:0] sample_i_i,
    input wire logic [15:0] sample_q_i,
    input wire logic [7:0] gain_setting_i,
    input wire logic overload_evt_i,
    input wire logic reset_evt_i,
    input wire logic large_signal_evt_i,
    output logic serial_data_o,
    output logic frame_sync_o,
    output logic frame_sync_oe_o,
    output logic bit_clock_o,
    output logic bit_clock_oe_o,
    output logic [1:0] drive_strength_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        iqs_state_t st;
        logic [7:0] ctrl_a;
        logic [1:0] ctrl_b;
        logic [3:0] divisor;
        logic ack;
        logic [31:0] rdat;
        logic pend;
        logic [15:0] hold_i;
        logic [15:0] hold_q;
        logic [7:0] hold_gain;
        logic [63:0] vec;
        logic [6:0] left;
        logic [3:0] idle;
        logic alt_phase;
        logic dout;
        logic fs;
        logic [3:0] run;
    } iqs_port_t;
    iqs_port_t cur;
    iqs_port_t next_cur;

    logic tick;
    logic clk_level;
    logic report;
    logic [1:0] cnt [3];
    logic [2:0] evt;
    logic [5:0] idx;
    logic req;
    logic embed_sync;
    logic start_ok;
    logic [7:0] bytes [IQS_MAX_BYTES];
    logic [2:0] nbytes;
    logic [6:0] len;
    logic [63:0] packed_vec;
    logic [7:0] status_byte;

    // ------------------------------------------------------------
    // Bit clock and event counters
    // ------------------------------------------------------------
    iqs_bit_clock u_clk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .divisor_i(cur.divisor),
        .level_o(clk_level),
        .tick_o(tick)
    );

    assign evt = {overload_evt_i, reset_evt_i, large_signal_evt_i};
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_cnt
            iqs_event_counter u_cnt (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .evt_i(evt[2 - g]),
                .clear_i(report),
                .count_o(cnt[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Frame assembly
    // ------------------------------------------------------------
    assign embed_sync = cur.ctrl_a[IQS_BIT_EMBED_SYNC];
    assign status_byte = {cnt[0], cnt[1], cnt[2], 1'b0, 1'b1};
    // Embedded sync needs the idle tail before another start bit
    assign start_ok = cur.pend && (!embed_sync || (cur.idle >= IQS_MIN_IDLE_BITS));

    always_comb
    begin
        bytes[0] = cur.hold_i[15:8];
        bytes[1] = cur.hold_i[7:0];
        bytes[2] = cur.hold_q[15:8];
        bytes[3] = cur.hold_q[7:0];
        bytes[4] = cur.hold_gain;
        bytes[5] = status_byte;
        nbytes = IQS_IQ_BYTES;
        if (cur.ctrl_a[IQS_BIT_EMBED_GAIN])
        begin
            if (cur.ctrl_a[IQS_BIT_ALT_GAIN])
            begin
                nbytes = IQS_IQ_BYTES + 3'h1;
                bytes[4] = cur.alt_phase ? status_byte : {cur.hold_gain[7:1], 1'b0};
            end
            else
            begin
                nbytes = IQS_IQ_BYTES + 3'h2;
            end
        end
        len = 7'h00;
        packed_vec = 64'h0;
        for (int k = 0; k < IQS_MAX_BYTES; k++)
        begin
            if (3'(k) < nbytes)
            begin
                if (embed_sync)
                begin
                    packed_vec = {packed_vec[53:0], 1'b0, bytes[k], 1'b1};
                    len = len + IQS_FRAMED_BYTE_BITS;
                end
                else
                begin
                    packed_vec = {packed_vec[55:0], bytes[k]};
                    len = len + IQS_PLAIN_BYTE_BITS;
                end
            end
        end
        packed_vec = packed_vec << (7'h40 - len);
    end

    // Counts are reported only in frames that carry the status byte
    assign report = tick && (cur.st == IQS_ST_IDLE) && start_ok && cur.ctrl_a[IQS_BIT_EMBED_GAIN]
                    && (!cur.ctrl_a[IQS_BIT_ALT_GAIN] || cur.alt_phase);

    // ------------------------------------------------------------
    // Wishbone slave and sequencer
    // ------------------------------------------------------------
    assign idx = wb_adr_i[7:2];
    assign req = wb_cyc_i && wb_stb_i && !cur.ack;

    always_comb
    begin
        next_cur = cur;
        next_cur.ack = req;
        if (req && wb_we_i && wb_sel_i[0])
        begin
            case (idx)
                IQS_IDX_CTRL_A: next_cur.ctrl_a = wb_dat_i[7:0];
                IQS_IDX_CTRL_B: next_cur.ctrl_b = wb_dat_i[1:0];
                IQS_IDX_DIVISOR: next_cur.divisor = wb_dat_i[3:0];
                default: next_cur.ctrl_a = cur.ctrl_a;
            endcase
        end
        if (req)
        begin
            case (idx)
                IQS_IDX_CTRL_A: next_cur.rdat = {24'h0, cur.ctrl_a};
                IQS_IDX_CTRL_B: next_cur.rdat = {30'h0, cur.ctrl_b};
                IQS_IDX_DIVISOR: next_cur.rdat = {28'h0, cur.divisor};
                IQS_IDX_STATUS: next_cur.rdat = {29'h0, cur.alt_phase, cur.pend, cur.st != IQS_ST_IDLE};
                default: next_cur.rdat = 32'h0;
            endcase
        end
        if (sample_valid_i)
        begin
            next_cur.hold_i = sample_i_i;
            next_cur.hold_q = sample_q_i;
            next_cur.hold_gain = gain_setting_i;
        end
        if (tick)
        begin
            // Own count of high bit periods, kept apart from the start logic it checks
            next_cur.run = (!cur.dout) ? 4'h0 : (cur.run == 4'hF) ? 4'hF : cur.run + 4'h1;
            case (cur.st)
                IQS_ST_IDLE:
                begin
                    next_cur.dout = 1'b1;
                    next_cur.fs = 1'b0;
                    if (cur.idle != IQS_MIN_IDLE_BITS)
                        next_cur.idle = cur.idle + 4'h1;
                    if (start_ok)
                    begin
                        next_cur.pend = 1'b0;
                        next_cur.vec = packed_vec;
                        next_cur.left = len;
                        if (cur.ctrl_a[IQS_BIT_EMBED_GAIN] && cur.ctrl_a[IQS_BIT_ALT_GAIN])
                            next_cur.alt_phase = !cur.alt_phase;
                        if (embed_sync)
                        begin
                            next_cur.st = IQS_ST_DATA;
                            next_cur.dout = packed_vec[63];
                            next_cur.vec = {packed_vec[62:0], 1'b1};
                            next_cur.left = len - 7'h01;
                        end
                        else
                        begin
                            next_cur.st = IQS_ST_SYNC;
                            next_cur.fs = !cur.ctrl_a[IQS_BIT_LATE_SYNC];
                        end
                    end
                end
                IQS_ST_SYNC:
                begin
                    next_cur.st = IQS_ST_DATA;
                    next_cur.dout = cur.vec[63];
                    next_cur.vec = {cur.vec[62:0], 1'b1};
                    next_cur.left = cur.left - 7'h01;
                    next_cur.fs = cur.ctrl_a[IQS_BIT_LATE_SYNC];
                end
                IQS_ST_DATA:
                begin
                    next_cur.fs = 1'b0;
                    if (cur.left == 7'h00)
                    begin
                        next_cur.st = IQS_ST_IDLE;
                        next_cur.dout = 1'b1;
                        next_cur.idle = 4'h1;
                    end
                    else
                    begin
                        next_cur.dout = cur.vec[63];
                        next_cur.vec = {cur.vec[62:0], 1'b1};
                        next_cur.left = cur.left - 7'h01;
                    end
                end
                default:
                begin
                    next_cur.st = IQS_ST_IDLE;
                    next_cur.dout = 1'b1;
                end
            endcase
        end
        // A new sample in the start cycle is not lost
        if (sample_valid_i)
            next_cur.pend = 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cur <= '0;
            cur.st <= IQS_ST_IDLE;
            cur.ctrl_a <= IQS_RST_CTRL_A;
            cur.ctrl_b <= IQS_RST_CTRL_B;
            cur.divisor <= IQS_RST_DIVISOR;
            cur.idle <= IQS_MIN_IDLE_BITS;
            cur.dout <= 1'b1;
            cur.run <= 4'hF;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // Pins
    // ------------------------------------------------------------
    assign wb_ack_o = cur.ack;
    assign wb_dat_o = cur.rdat;
    assign serial_data_o = cur.dout;
    // Pulse only without embedded sync; embedded mode keeps the pin low
    assign frame_sync_o = !embed_sync && (cur.fs ^ cur.ctrl_a[IQS_BIT_SYNC_INV]);
    assign frame_sync_oe_o = !cur.ctrl_a[IQS_BIT_SYNC_3ST];
    assign bit_clock_o = clk_level ^ cur.ctrl_a[IQS_BIT_CLK_INV];
    assign bit_clock_oe_o = !cur.ctrl_a[IQS_BIT_CLK_3ST];
    assign drive_strength_o = cur.ctrl_b;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_single_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_idle_line_high: assert property (cur.st == IQS_ST_IDLE |-> serial_data_o)
        else $error("data line not idle high");
    a_early_sync_pulse: assert property (cur.st == IQS_ST_SYNC && !cur.ctrl_a[IQS_BIT_LATE_SYNC]
        && !cur.ctrl_a[IQS_BIT_SYNC_INV] |-> frame_sync_o)
        else $error("early sync pulse missing");
    a_late_sync_pulse: assert property (tick && cur.st == IQS_ST_SYNC && cur.ctrl_a[IQS_BIT_LATE_SYNC]
        && $stable(cur.ctrl_a) |=> frame_sync_o == !cur.ctrl_a[IQS_BIT_SYNC_INV])
        else $error("late sync pulse not on first data bit");
    a_embed_sync_low: assert property (embed_sync |-> !frame_sync_o)
        else $error("sync pin active in embedded mode");
    a_embed_idle_tail: assert property (embed_sync && tick && cur.st == IQS_ST_IDLE && start_ok
        |-> cur.run >= IQS_MIN_IDLE_BITS)
        else $error("embedded frame started before idle tail");
    a_tick_spacing: assert property (tick && cur.divisor == 4'h2 && !(req && wb_we_i)
        |=> !tick [*3] ##1 tick)
        else $error("bit period wrong for divisor two");
    a_plain_frame_len: assert property (tick && cur.st == IQS_ST_IDLE && start_ok && !embed_sync
        && !cur.ctrl_a[IQS_BIT_EMBED_GAIN] |=> cur.left == 7'h20)
        else $error("plain frame length not 32 bits");
    a_pend_set_wins: assert property (sample_valid_i |=> cur.pend)
        else $error("new sample lost");

    c_pulse_frame: cover property (cur.st == IQS_ST_SYNC && tick);
    c_embed_frame: cover property (embed_sync && cur.st == IQS_ST_DATA && cur.left == 7'h00 && tick);
    c_alt_status: cover property (report && cur.ctrl_a[IQS_BIT_ALT_GAIN]);
endmodule : iqs_serial_port
`default_nettype wire

// file: include/iqs_pkg.sv
// Purpose: Shared constants for the I/Q sample serial output port
// Assumes: 32-bit classic Wishbone, registers on word addresses
// Notes: Register byte address is four times the register index
package iqs_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [5:0] IQS_IDX_CTRL_A = 6'h18;
    localparam logic [5:0] IQS_IDX_CTRL_B = 6'h19;
    localparam logic [5:0] IQS_IDX_DIVISOR = 6'h1A;
    localparam logic [5:0] IQS_IDX_STATUS = 6'h1B;
    localparam logic [7:0] IQS_RST_CTRL_A = 8'h12;
    localparam logic [1:0] IQS_RST_CTRL_B = 2'h0;
    localparam logic [3:0] IQS_RST_DIVISOR = 4'h1;
    // ------------------------------------------------------------
    // Control A field positions
    // ------------------------------------------------------------
    localparam int IQS_BIT_ALT_GAIN = 7;
    localparam int IQS_BIT_EMBED_GAIN = 6;
    localparam int IQS_BIT_EMBED_SYNC = 5;
    localparam int IQS_BIT_SYNC_3ST = 4;
    localparam int IQS_BIT_SYNC_INV = 3;
    localparam int IQS_BIT_LATE_SYNC = 2;
    localparam int IQS_BIT_CLK_3ST = 1;
    localparam int IQS_BIT_CLK_INV = 0;
    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int IQS_MAX_BYTES = 6;
    localparam logic [2:0] IQS_IQ_BYTES = 3'h4;
    localparam logic [6:0] IQS_PLAIN_BYTE_BITS = 7'h08;
    localparam logic [6:0] IQS_FRAMED_BYTE_BITS = 7'h0A;
    localparam logic [3:0] IQS_MIN_IDLE_BITS = 4'hA;
    localparam logic [1:0] IQS_CNT_MAX = 2'h3;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        IQS_ST_IDLE = 3'b001,
        IQS_ST_SYNC = 3'b010,
        IQS_ST_DATA = 3'b100
    } iqs_state_t;
endpackage : iqs_pkg

// file: tb/iqs_rx_model.sv
// Purpose: Receiving processor model for the I/Q serial frames
// Assumes: Data is taken on the falling edge of the clock it is given
// Notes: Framing faults are counted, not fatal
`timescale 1ns/1ns
`default_nettype none
module iqs_rx_model
(
    input wire logic rst_i,
    input wire logic bclk_i,
    input wire logic data_i,
    input wire logic sync_i,
    input wire logic embedded_i,
    input wire logic late_i,
    input wire logic [5:0] nbits_i,
    output logic [47:0] frame_o,
    output int frames_o,
    output int errors_o
);
    // ------------------------------------------------------------
    // Deserialiser
    // ------------------------------------------------------------
    int cnt = 0;
    int pos = 0;
    // Line idles high from reset, so the first frame meets the tail
    int idle = 10;
    logic busy = 1'b0;
    always @(negedge bclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            busy = 1'b0;
            idle = 10;
        end
        else if (!busy && embedded_i)
        begin
            if (data_i === 1'b0)
            begin
                if (idle < 10)
                    errors_o++;
                busy = 1'b1;
                cnt = nbits_i;
                pos = 1;
                frame_o = '0;
            end
            idle = (data_i === 1'b1) ? idle + 1 : 0;
        end
        else if (!busy)
        begin
            if (sync_i === 1'b1)
            begin
                busy = 1'b1;
                cnt = nbits_i - late_i;
                frame_o = late_i ? {47'h0, data_i} : '0;
            end
        end
        else if (embedded_i && pos == 0)
        begin
            if (data_i !== 1'b0)
                errors_o++;
            pos = 1;
        end
        else if (embedded_i && pos == 9)
        begin
            if (data_i !== 1'b1)
                errors_o++;
            pos = 0;
            if (cnt == 0)
            begin
                busy = 1'b0;
                idle = 1;
                frames_o++;
            end
        end
        else
        begin
            frame_o = {frame_o[46:0], data_i};
            cnt--;
            pos++;
            if (!embedded_i && cnt == 0)
            begin
                busy = 1'b0;
                frames_o++;
            end
        end
    end
endmodule : iqs_rx_model
`default_nettype wire

// file: tb/iqs_serial_port_tb.sv
// Purpose: Self-checking bench for the I/Q serial output port
// Assumes: Receiver model decodes every frame the port sends
// Notes: Drivers queue expected frames and read data
`timescale 1ns/1ns
`default_nettype none
`define CHK(name, exp, got) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
    $display("Error %s expected %0h seen %0h", name, exp, got); end end
module iqs_serial_port_tb
    import iqs_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic sample_valid_i = 1'b0;
    logic [15:0] sample_i_i = 16'h0;
    logic [15:0] sample_q_i = 16'h0;
    logic [7:0] gain_setting_i = 8'h00;
    logic [2:0] evt = 3'h0;
    logic serial_data_o, frame_sync_o, frame_sync_oe_o, bit_clock_o, bit_clock_oe_o;
    logic [1:0] drive_strength_o;
    logic [7:0] cfg = 8'h00;
    logic [5:0] nbits = 6'd32;
    logic [47:0] rx_frame, exp_f;
    logic [31:0] exp_w;
    logic [47:0] exp_fr[$];
    logic [31:0] exp_rd[$];
    int rx_frames, rx_errors, fail_count, comparisons, cycles, n0, phase;
    int a[3];
    int k[3];
    int unsigned seed;
    // Sixteen-bit words and byte fields used by the frame driver
    logic [15:0] si, sq;
    logic [7:0] g, st;
    logic [1:0] dv;
    logic [3:0] div;
    time t0;
    logic [7:0] cfgs[9] = '{8'h00, 8'h04, 8'h49, 8'hC0, 8'h20, 8'h60, 8'hE0, 8'h28, 8'h30};
    logic [3:0] divs[9] = '{4'h1, 4'h3, 4'hF, 4'h2, 4'h1, 4'h2, 4'h1, 4'h3, 4'h1};
    // Pins as the receiver sees them; released pins float
    wire logic bclk_pin = bit_clock_oe_o ? bit_clock_o : 1'bz;
    wire logic fs_pin = frame_sync_oe_o ? frame_sync_o : 1'bz;

    iqs_serial_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .sample_valid_i(sample_valid_i), .sample_i_i(sample_i_i),
        .sample_q_i(sample_q_i), .gain_setting_i(gain_setting_i), .overload_evt_i(evt[0]),
        .reset_evt_i(evt[1]), .large_signal_evt_i(evt[2]), .serial_data_o(serial_data_o),
        .frame_sync_o(frame_sync_o), .frame_sync_oe_o(frame_sync_oe_o), .bit_clock_o(bit_clock_o),
        .bit_clock_oe_o(bit_clock_oe_o), .drive_strength_o(drive_strength_o));
    iqs_rx_model u_rx (.rst_i(rst_i), .bclk_i(bclk_pin ^ cfg[0]), .data_i(serial_data_o),
        .sync_i(fs_pin ^ cfg[3]), .embedded_i(cfg[5]), .late_i(cfg[2]), .nbits_i(nbits),
        .frame_o(rx_frame), .frames_o(rx_frames), .errors_o(rx_errors));

    // ------------------------------------------------------------
    // Clock, timeout and watchers
    // ------------------------------------------------------------
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fail_count++;
            $display("Error timeout expected done seen running");
            complete_run();
        end
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
        begin
            exp_w = exp_rd.pop_front();
            `CHK("read data", exp_w, wb_dat_o)
        end
    end
    always @(rx_frames)
    begin
        // Frame word and count reach the bench by separate ports; let both settle
        @(posedge clk_i);
        exp_f = exp_fr.pop_front();
        `CHK("frame", exp_f, rx_frame)
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wb(input logic w, input logic [5:0] idx, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic rd(input logic [5:0] idx, input logic [31:0] e);
        exp_rd.push_back(e);
        wb(1'b0, idx, 32'h0);
    endtask : rd
    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // Main sequence: one reset and configuration per format
    // ------------------------------------------------------------
    initial
    begin
        seed = $urandom(40);
        for (int c = 0; c < 9; c++)
        begin
            rst_i <= 1'b1;
            repeat (16) @(posedge clk_i);
            rst_i <= 1'b0;
            @(posedge clk_i);
            rd(IQS_IDX_CTRL_A, {24'h0, IQS_RST_CTRL_A});
            rd(IQS_IDX_DIVISOR, {28'h0, IQS_RST_DIVISOR});
            rd(6'h00, 32'h0);
            rd(IQS_IDX_STATUS, 32'h0);
            `CHK("reset clock enable", 1'b0, bit_clock_oe_o)
            `CHK("reset sync enable", 1'b0, frame_sync_oe_o)
            dv = 2'($urandom);
            wb(1'b1, IQS_IDX_CTRL_B, {30'h0, dv});
            rd(IQS_IDX_CTRL_B, {30'h0, dv});
            div = divs[c];
            // Model takes the new format while both pins are still released
            cfg = cfgs[c];
            nbits = cfg[6] ? (cfg[7] ? 6'h28 : 6'h30) : 6'h20;
            wb(1'b1, IQS_IDX_CTRL_A, {24'h0, cfgs[c]});
            wb(1'b1, IQS_IDX_DIVISOR, {28'h0, div});
            rd(IQS_IDX_CTRL_A, {24'h0, cfg});
            @(posedge clk_i);
            `CHK("drive strength", dv, drive_strength_o)
            `CHK("sync enable", !cfg[4], frame_sync_oe_o)
            `CHK("clock enable", 1'b1, bit_clock_oe_o)
            if (cfg[5])
                `CHK("sync level", 1'b0, frame_sync_o)
            @(posedge bclk_pin);
            t0 = $time;
            @(posedge bclk_pin);
            `CHK("bit period", {59'h0, div, 1'b0}, 64'(($time - t0) / 10))
            a = '{0, 0, 0};
            phase = 0;
            for (int f = 0; f < 3; f++)
            begin
                for (int j = 0; j < 3; j++)
                    k[j] = $urandom_range(4, 0);
                for (int i = 0; i < 4; i++)
                begin
                    @(posedge clk_i);
                    evt <= {3'(i < k[2]), 3'(i < k[1]), 3'(i < k[0])} != 0 ? {i < k[2], i < k[1], i < k[0]} : 3'h0;
                    @(posedge clk_i);
                    evt <= 3'h0;
                end
                for (int j = 0; j < 3; j++)
                    a[j] = a[j] + k[j];
                si = 16'($urandom);
                sq = 16'($urandom);
                g = 8'($urandom);
                st = {2'(a[0] > 3 ? 3 : a[0]), 2'(a[1] > 3 ? 3 : a[1]), 2'(a[2] > 3 ? 3 : a[2]), 2'b01};
                if (!cfg[6])
                    exp_f = {16'h0, si, sq};
                else if (!cfg[7])
                    exp_f = {si, sq, g, st};
                else if (phase == 0)
                    exp_f = {8'h0, si, sq, g[7:1], 1'b0};
                else
                    exp_f = {8'h0, si, sq, st};
                if (cfg[6] && (!cfg[7] || phase == 1))
                    a = '{0, 0, 0};
                if (cfg[7])
                    phase = 1 - phase;
                exp_fr.push_back(exp_f);
                n0 = rx_frames;
                @(posedge clk_i);
                sample_valid_i <= 1'b1;
                sample_i_i <= si;
                sample_q_i <= sq;
                gain_setting_i <= g;
                @(posedge clk_i);
                sample_valid_i <= 1'b0;
                wait (rx_frames != n0);
                repeat (4 * div + 2) @(posedge clk_i);
                `CHK("idle data", 1'b1, serial_data_o)
            end
        end
        `CHK("framing faults", 0, rx_errors)
        `CHK("frames left", 0, exp_fr.size())
        complete_run();
    end
endmodule : iqs_serial_port_tb
`default_nettype wire
